/* rtl/mpfs_consts.vh */
// Constants for the multiphase PWM fault sequencer
`ifndef MPFS_CONSTS_VH
`define MPFS_CONSTS_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define MPFS_CLK_MHZ 250
`define MPFS_SKEW_NS 400
`define MPFS_SKEW_CYC ((`MPFS_SKEW_NS * `MPFS_CLK_MHZ + 999) / 1000)
`define MPFS_STEP_NS 2000
`define MPFS_STEP_CYC ((`MPFS_STEP_NS * `MPFS_CLK_MHZ + 999) / 1000)
`define MPFS_OSC_HALF_DEF 125

// ----------------------------------------
// DAC levels, one count is 12.5 mV
// ----------------------------------------
`define MPFS_OTF_WINDOW 8'd20
`define MPFS_L5_TOP_HI 8'd148
`define MPFS_L5_TOP_LO 8'd116
`define MPFS_L6_TOP 8'd128
`define MPFS_OVP_STEPS6 8'd16
`define MPFS_OVP_STEPS5 8'd18

// ----------------------------------------
// Current limit
// ----------------------------------------
`define MPFS_CURRENT_LIMIT_SET_PIN_DEF_MV 8'd20

// ----------------------------------------
// Async input vector fields
// ----------------------------------------
`define MPFS_A_EN 0
`define MPFS_A_SUP 1
`define MPFS_A_REFHI 2
`define MPFS_A_REFLO 3
`define MPFS_A_HOT 4
`define MPFS_A_COOL 5
`define MPFS_A_OVP 6
`define MPFS_A_PGHI 7
`define MPFS_A_PGLO 8
`define MPFS_A_SYNC 9
`define MPFS_A_STR2 10
`define MPFS_A_STR4 11
`define MPFS_A_CURRENT_LIMIT_SET_PIN 12
`define MPFS_A_CS 13
`define MPFS_A_END 17
`define MPFS_A_VID 21
`define MPFS_A_W 27

`endif

/* rtl/mpfs_vid_stepper.v */
// Voltage-ID skew filter and reference DAC stepper
`timescale 1ns/1ns
`include "mpfs_consts.vh"

module mpfs_vid_stepper
#(
  parameter SIX_BIT = 1
)
(
  // Clock and reset
  input wire clock,
  input wire rst,
  // Control
  input wire ss_start,
  input wire active,
  input wire [5:0] vid_code,
  // Status
  output reg [7:0] dac_level_reg,
  output wire at_target,
  output wire vid_shutdown
);

  // ----------------------------------------
  // Code to level
  // ----------------------------------------
  function [7:0] vid_level;
    input [5:0] c;
    begin
      if (SIX_BIT != 0)
        vid_level = `MPFS_L6_TOP - {2'h0, c};
      else if (c[4] == 1'b0)
        vid_level = `MPFS_L5_TOP_HI - {3'h0, c[3:0], 1'b0};
      else
        vid_level = `MPFS_L5_TOP_LO - {3'h0, c[3:0], 1'b0};
    end
  endfunction

  reg [5:0] last_reg;
  reg [6:0] skew_reg;
  reg [7:0] target_reg;
  reg [9:0] step_reg;
  reg soft_reg;
  wire [7:0] new_lvl;
  wire [7:0] diff;
  wire stable;

  assign new_lvl = vid_level(last_reg);
  assign diff = (new_lvl > dac_level_reg) ? new_lvl - dac_level_reg :
    dac_level_reg - new_lvl;
  assign stable = (skew_reg == `MPFS_SKEW_CYC - 1);
  assign at_target = (dac_level_reg == target_reg);
  assign vid_shutdown = (SIX_BIT == 0) && (last_reg[4:0] == 5'h1f);

  // ----------------------------------------
  // Skew filter and stepping
  // ----------------------------------------
  always @(posedge clock)
  begin
    if (rst)
    begin
      last_reg <= 6'h00;
      skew_reg <= 7'h00;
      target_reg <= 8'h00;
      step_reg <= 10'h000;
      soft_reg <= 1'b0;
      dac_level_reg <= 8'h00;
    end
    else
    begin
      if (vid_code != last_reg)
      begin
        last_reg <= vid_code;
        skew_reg <= 7'h00;
      end
      else if (!stable)
        skew_reg <= skew_reg + 7'h01;
      // Out-of-window requests are held off while regulating
      if (stable && (soft_reg || ss_start || diff <= `MPFS_OTF_WINDOW))
        target_reg <= new_lvl;
      if (ss_start)
      begin
        dac_level_reg <= 8'h00;
        soft_reg <= 1'b1;
        step_reg <= 10'h000;
        // Stale target would end soft-start at once
        target_reg <= new_lvl;
      end
      else if (!active)
      begin
        dac_level_reg <= 8'h00;
        soft_reg <= 1'b0;
        step_reg <= 10'h000;
      end
      else if (at_target)
      begin
        soft_reg <= 1'b0;
        step_reg <= 10'h000;
      end
      else if (step_reg == `MPFS_STEP_CYC - 1)
      begin
        step_reg <= 10'h000;
        if (target_reg > dac_level_reg)
          dac_level_reg <= dac_level_reg + 8'h01;
        else
          dac_level_reg <= dac_level_reg - 8'h01;
      end
      else
        step_reg <= step_reg + 10'h001;
    end
  end

endmodule // mpfs_vid_stepper

/* rtl/mpfs_sequencer.v */
// Multiphase PWM control, protection and start-up sequencing
`timescale 1ns/1ns
`include "mpfs_consts.vh"

module mpfs_sequencer
#(
  parameter SIX_BIT = 1,
  parameter OSC_HALF = `MPFS_OSC_HALF_DEF
)
(
  // Clock and reset
  input wire clock,
  input wire rst,
  // Start-up and supervisor comparators
  input wire enable_pin,
  input wire supply_ok,
  input wire ref_above_set,
  input wire ref_above_clear,
  input wire temp_over_trip,
  input wire temp_cooled,
  input wire out_over_ovp,
  input wire out_above_pg_hi,
  input wire out_below_pg_lo,
  // Straps
  input wire current_limit_set_pin,
  input wire strap_second,
  input wire strap_fourth,
  input wire [7:0] current_limit_set_pin_prog_mv,
  // Clocking
  input wire master_mode,
  input wire sync_clock_in,
  output reg sync_clock_out,
  // Per phase comparators
  input wire [3:0] phase_over_limit,
  input wire [3:0] phase_loop_end,
  // Processor code
  input wire [5:0] voltage_id_code,
  // Phase drives
  output reg [3:0] phase_drive,
  // Power-good open drain
  output wire power_good_out,
  output reg power_good_oe,
  // Status
  output reg [7:0] current_limit_set_pin_threshold_mv,
  output reg [7:0] ovp_margin_steps,
  output wire [7:0] dac_level,
  output reg [2:0] phase_count,
  output reg overvoltage_trip,
  output reg thermal_shutdown,
  output reg soft_start_active
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_OFF = 5'b00001;
  localparam ST_SOFT = 5'b00010;
  localparam ST_RUN = 5'b00100;
  localparam ST_OVL = 5'b01000;
  localparam ST_HOT = 5'b10000;

  // ----------------------------------------
  // Phase slot to output index
  // ----------------------------------------
  function [1:0] slot_phase;
    input [1:0] slot;
    input [2:0] n;
    begin
      if (n == 3'd2)
        slot_phase = {slot[0], 1'b0};
      else
        slot_phase = slot;
    end
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg [`MPFS_A_W-1:0] a1_reg;
  reg [`MPFS_A_W-1:0] a2_reg;
  wire [`MPFS_A_W-1:0] a_raw;

  assign a_raw = {voltage_id_code, phase_loop_end, phase_over_limit,
    current_limit_set_pin, strap_fourth, strap_second, sync_clock_in,
    out_below_pg_lo, out_above_pg_hi, out_over_ovp, temp_cooled,
    temp_over_trip, ref_above_clear, ref_above_set, supply_ok, enable_pin};

  always @(posedge clock)
  begin
    if (rst)
    begin
      a1_reg <= {`MPFS_A_W{1'b0}};
      a2_reg <= {`MPFS_A_W{1'b0}};
    end
    else
    begin
      a1_reg <= a_raw;
      a2_reg <= a1_reg;
    end
  end

  wire en_s = a2_reg[`MPFS_A_EN];
  wire sup_s = a2_reg[`MPFS_A_SUP];
  wire ovp_s = a2_reg[`MPFS_A_OVP];
  wire pghi_s = a2_reg[`MPFS_A_PGHI];
  wire pglo_s = a2_reg[`MPFS_A_PGLO];
  wire sync_s = a2_reg[`MPFS_A_SYNC];
  wire [3:0] over_s = a2_reg[`MPFS_A_CS+3:`MPFS_A_CS];
  wire [3:0] end_s = a2_reg[`MPFS_A_END+3:`MPFS_A_END];
  wire [5:0] vid_s = a2_reg[`MPFS_A_VID+5:`MPFS_A_VID];

  // ----------------------------------------
  // Reference and thermal hysteresis
  // ----------------------------------------
  reg ref_ok_reg;

  always @(posedge clock)
  begin
    if (rst)
    begin
      ref_ok_reg <= 1'b0;
      thermal_shutdown <= 1'b0;
    end
    else
    begin
      if (a2_reg[`MPFS_A_REFHI])
        ref_ok_reg <= 1'b1;
      else if (!a2_reg[`MPFS_A_REFLO])
        ref_ok_reg <= 1'b0;
      // Trip wins over the cooled indication
      if (a2_reg[`MPFS_A_HOT])
        thermal_shutdown <= 1'b1;
      else if (a2_reg[`MPFS_A_COOL])
        thermal_shutdown <= 1'b0;
    end
  end

  // ----------------------------------------
  // Strap capture after reset
  // ----------------------------------------
  reg [1:0] strap_cnt_reg;
  reg strap_done_reg;
  reg current_limit_set_pin_def_reg;

  always @(posedge clock)
  begin
    if (rst)
    begin
      strap_cnt_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      phase_count <= 3'd4;
      current_limit_set_pin_def_reg <= 1'b0;
    end
    else if (!strap_done_reg)
    begin
      // Wait out the synchroniser before trusting straps
      if (strap_cnt_reg == 2'h3)
      begin
        strap_done_reg <= 1'b1;
        current_limit_set_pin_def_reg <= a2_reg[`MPFS_A_CURRENT_LIMIT_SET_PIN];
        if (a2_reg[`MPFS_A_STR4] && a2_reg[`MPFS_A_STR2])
          phase_count <= 3'd2;
        else if (a2_reg[`MPFS_A_STR4])
          phase_count <= 3'd3;
        else
          phase_count <= 3'd4;
      end
      else
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg ss_start;
  wire at_target;
  wire vid_off;
  wire can_start;
  wire lockout;

  // Overvoltage latch sits above everything else; lockout leads the exits from soft-start and run
  assign lockout = !sup_s;
  assign can_start = strap_done_reg && sup_s && ref_ok_reg && en_s &&
    !thermal_shutdown && !vid_off;

  always @*
  begin
    state_next = state_reg;
    ss_start = 1'b0;
    case (state_reg)
      ST_OFF:
      begin
        if (can_start)
        begin
          state_next = ST_SOFT;
          ss_start = 1'b1;
        end
      end
      ST_SOFT, ST_RUN:
      begin
        if (lockout || !ref_ok_reg || !en_s || vid_off)
          state_next = ST_OFF;
        else if (thermal_shutdown)
          state_next = ST_HOT;
        else if (state_reg == ST_SOFT && at_target)
          state_next = ST_RUN;
      end
      ST_HOT:
      begin
        if (!thermal_shutdown)
          state_next = ST_OFF;
      end
      ST_OVL:
        state_next = ST_OVL;
      default:
        state_next = ST_OFF;
    endcase
    if (overvoltage_trip)
      state_next = ST_OVL;
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      state_reg <= ST_OFF;
      overvoltage_trip <= 1'b0;
      soft_start_active <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      // Only a power-on reset releases this latch
      if ((state_reg == ST_SOFT || state_reg == ST_RUN) && ovp_s)
        overvoltage_trip <= 1'b1;
      soft_start_active <= (state_next == ST_SOFT);
    end
  end

  mpfs_vid_stepper #(.SIX_BIT(SIX_BIT)) u_stepper
  (
    .clock(clock),
    .rst(rst),
    .ss_start(ss_start),
    .active(state_reg == ST_SOFT || state_reg == ST_RUN),
    .vid_code(SIX_BIT != 0 ? vid_s : {1'b0, vid_s[4:0]}),
    .dac_level_reg(dac_level),
    .at_target(at_target),
    .vid_shutdown(vid_off)
  );

  // ----------------------------------------
  // Oscillator and interleave timing
  // ----------------------------------------
  reg [15:0] osc_reg;
  reg sync_out_d_reg;
  reg sync_in_d_reg;
  reg [1:0] slot_reg;
  wire tick;
  wire [1:0] next_slot;
  wire [1:0] ph;

  always @(posedge clock)
  begin
    if (rst)
    begin
      osc_reg <= 16'h0000;
      sync_clock_out <= 1'b0;
      sync_out_d_reg <= 1'b0;
      sync_in_d_reg <= 1'b0;
    end
    else
    begin
      if (osc_reg == OSC_HALF[15:0] - 16'h0001)
      begin
        osc_reg <= 16'h0000;
        sync_clock_out <= !sync_clock_out;
      end
      else
        osc_reg <= osc_reg + 16'h0001;
      sync_out_d_reg <= sync_clock_out;
      sync_in_d_reg <= sync_s;
    end
  end

  // Slave is fed from the master output by board wiring
  assign tick = master_mode ? (sync_clock_out && !sync_out_d_reg) :
    (!sync_s && sync_in_d_reg);
  assign next_slot = ({1'b0, slot_reg} + 3'd1 >= phase_count) ? 2'h0 :
    slot_reg + 2'h1;
  assign ph = slot_phase(next_slot, phase_count);

  // ----------------------------------------
  // Phase drives and current limit
  // ----------------------------------------
  wire running;

  assign running = (state_reg == ST_SOFT || state_reg == ST_RUN) &&
    !overvoltage_trip && !thermal_shutdown && !lockout;

  always @(posedge clock)
  begin
    if (rst)
    begin
      slot_reg <= 2'h0;
      phase_drive <= 4'h0;
    end
    else if (!running)
    begin
      slot_reg <= 2'h0;
      phase_drive <= 4'h0;
    end
    else
    begin
      // Pulse ends on loop comparator or limit, whichever first
      phase_drive <= phase_drive & ~over_s & ~end_s;
      if (tick)
      begin
        slot_reg <= next_slot;
        // Comparator already tracks the folded threshold
        if (!over_s[ph])
          phase_drive[ph] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Thresholds and power-good
  // ----------------------------------------
  wire [7:0] base_mv;
  wire fold;

  assign base_mv = current_limit_set_pin_def_reg ? `MPFS_CURRENT_LIMIT_SET_PIN_DEF_MV : current_limit_set_pin_prog_mv;
  assign fold = pglo_s || state_reg == ST_SOFT;
  assign power_good_out = 1'b0;

  always @(posedge clock)
  begin
    if (rst)
    begin
      current_limit_set_pin_threshold_mv <= 8'h00;
      ovp_margin_steps <= 8'h00;
      power_good_oe <= 1'b1;
    end
    else
    begin
      current_limit_set_pin_threshold_mv <= fold ? {1'b0, base_mv[7:1]} : base_mv;
      ovp_margin_steps <= (SIX_BIT != 0) ? `MPFS_OVP_STEPS6 :
        `MPFS_OVP_STEPS5;
      power_good_oe <= !(state_next == ST_RUN && running &&
        !pghi_s && !pglo_s);
    end
  end

endmodule // mpfs_sequencer

/* verif/mpfs_sequencer_properties.sv */
// Port-level checks for the sequencer
`timescale 1ns/1ns

module mpfs_seq_props
#(
  parameter SIX_BIT = 1
)
(
  // Clock and reset
  input wire clock,
  input wire rst,
  // Inputs
  input wire supply_ok,
  input wire out_above_pg_hi,
  input wire [3:0] phase_over_limit,
  // Outputs
  input wire [3:0] phase_drive,
  input wire power_good_oe,
  input wire [7:0] dac_level,
  input wire [7:0] ovp_margin_steps,
  input wire overvoltage_trip,
  input wire thermal_shutdown,
  input wire soft_start_active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ------------------------------
  // Cycles since the last step
  // ------------------------------
  reg [7:0] last_reg;
  reg [15:0] gap_reg;
  always @(posedge clock)
  begin
    last_reg <= dac_level;
    gap_reg <= rst ? 16'h0 : (dac_level != last_reg) ? 16'h0 :
      gap_reg + {15'h0, ~&gap_reg};
  end

  a_trip_outputs_low: assert property (overvoltage_trip |=>
    phase_drive == 4'h0) else $error("drive after trip");
  a_trip_latch_hold: assert property (overvoltage_trip |=>
    overvoltage_trip) else $error("trip latch cleared");
  a_trip_margin: assert property (!$past(rst) |->
    ovp_margin_steps == (SIX_BIT ? 8'h10 : 8'h12))
    else $error("wrong trip margin");
  a_hot_outputs_low: assert property (thermal_shutdown |=>
    phase_drive == 4'h0) else $error("drive while hot");
  a_lockout_outputs_low: assert property (!supply_ok [*6] |->
    phase_drive == 4'h0) else $error("drive in lockout");
  a_soft_pg_low: assert property (soft_start_active |->
    power_good_oe) else $error("good during soft start");
  a_window_pg_low: assert property (out_above_pg_hi [*5] |->
    power_good_oe) else $error("good above window");
  a_limit_cut: assert property (phase_over_limit[0] [*4] |->
    !phase_drive[0]) else $error("drive over limit");
  a_dac_unit_step: assert property ($changed(dac_level) &&
    dac_level != 8'h0 |-> dac_level == $past(dac_level) + 8'h1 ||
    dac_level == $past(dac_level) - 8'h1) else $error("dac jump");
  a_dac_step_spacing: assert property ($changed(dac_level) &&
    dac_level != 8'h0 && $past(dac_level) != 8'h0 |->
    gap_reg >= 16'd490) else $error("dac step too soon");

  cover property (overvoltage_trip);
  cover property (thermal_shutdown);
  cover property ($fell(soft_start_active));
endmodule // mpfs_seq_props

bind mpfs_sequencer mpfs_seq_props #(.SIX_BIT(SIX_BIT)) i_mpfs_seq_props (
  .clock(clock), .rst(rst), .supply_ok(supply_ok),
  .out_above_pg_hi(out_above_pg_hi), .phase_over_limit(phase_over_limit),
  .phase_drive(phase_drive), .power_good_oe(power_good_oe),
  .dac_level(dac_level), .ovp_margin_steps(ovp_margin_steps),
  .overvoltage_trip(overvoltage_trip), .thermal_shutdown(thermal_shutdown),
  .soft_start_active(soft_start_active));

/* verif/mpfs_drv_model.sv */
// Gate-driver and current-sense stand-in
`timescale 1ns/1ns

module mpfs_drv_model
#(
  parameter ON = 3
)
(
  // Clock
  input wire clock,
  // Phase side
  input wire [3:0] phase_drive,
  input wire [3:0] force_over,
  output reg [3:0] phase_loop_end,
  output wire [3:0] phase_over_limit
);
  reg [3:0] line_reg [0:7];
  integer i;
  // Low drive reads as low-side on, high-side off
  always @(posedge clock)
  begin
    line_reg[0] <= phase_drive;
    for (i = 1; i < 8; i = i + 1)
      line_reg[i] <= line_reg[i - 1];
    phase_loop_end <= line_reg[ON - 1];
  end
  // Overload only when the bench asks for it
  assign phase_over_limit = force_over;
endmodule // mpfs_drv_model

/* verif/mpfs_sequencer_tb_top.sv */
// Self-checking bench for the sequencer
`timescale 1ns/1ns

module mpfs_sequencer_tb_top;
  reg clock = 1'b0, rst = 1'b1, enable_pin = 1'b0, supply_ok = 1'b1;
  reg ref_above_set = 1'b0, ref_above_clear = 1'b1, temp_over_trip = 1'b0;
  reg temp_cooled = 1'b0, out_over_ovp = 1'b0, out_above_pg_hi = 1'b0;
  reg out_below_pg_lo = 1'b0, current_limit_set_pin = 1'b1;
  reg strap_second = 1'b0, strap_fourth = 1'b0, master_mode = 1'b1;
  reg [7:0] current_limit_set_pin_prog_mv = 8'h28;
  reg [5:0] voltage_id_code = 6'h3f;
  reg [3:0] force_over = 4'h0;
  reg [3:0] p;
  wire sync_clock_out, power_good_oe, overvoltage_trip;
  wire thermal_shutdown, soft_start_active, pg_pin;
  wire [3:0] phase_drive, phase_loop_end, phase_over_limit;
  wire [7:0] current_limit_set_pin_threshold_mv, dac_level;
  wire [2:0] phase_count;
  integer errors = 0, cmp_count = 0, n;

  always #2 clock = ~clock;

  // Master loops its own sync output back
  mpfs_sequencer #(.SIX_BIT(1), .OSC_HALF(4)) i_mpfs_sequencer (
    .clock(clock), .rst(rst), .enable_pin(enable_pin),
    .supply_ok(supply_ok), .ref_above_set(ref_above_set),
    .ref_above_clear(ref_above_clear), .temp_over_trip(temp_over_trip),
    .temp_cooled(temp_cooled), .out_over_ovp(out_over_ovp),
    .out_above_pg_hi(out_above_pg_hi), .out_below_pg_lo(out_below_pg_lo),
    .current_limit_set_pin(current_limit_set_pin),
    .strap_second(strap_second), .strap_fourth(strap_fourth),
    .current_limit_set_pin_prog_mv(current_limit_set_pin_prog_mv), .master_mode(master_mode),
    .sync_clock_in(sync_clock_out), .sync_clock_out(sync_clock_out),
    .phase_over_limit(phase_over_limit), .phase_loop_end(phase_loop_end),
    .voltage_id_code(voltage_id_code), .phase_drive(phase_drive),
    .power_good_out(pg_pin), .power_good_oe(power_good_oe),
    .current_limit_set_pin_threshold_mv(current_limit_set_pin_threshold_mv), .ovp_margin_steps(),
    .dac_level(dac_level), .phase_count(phase_count),
    .overvoltage_trip(overvoltage_trip),
    .thermal_shutdown(thermal_shutdown),
    .soft_start_active(soft_start_active));

  mpfs_drv_model i_mpfs_drv_model (.clock(clock),
    .phase_drive(phase_drive), .force_over(force_over),
    .phase_loop_end(phase_loop_end), .phase_over_limit(phase_over_limit));

  task cyc(input integer k);
    repeat (k) @(posedge clock);
  endtask

  task chk(input [7:0] seen, input [7:0] exp, input [63:0] what);
    begin
      @(negedge clock);
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
        errors = errors + 1;
        $display("mismatch %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask

  task final_report;
    begin
      $display("compares %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  task wait_dac(input [7:0] v, input integer lim);
    begin
      n = 0;
      while (dac_level !== v && n < lim)
      begin
        @(posedge clock);
        n = n + 1;
      end
      if (n >= lim)
      begin
        chk(8'h0, 8'h1, "timeout");
        final_report;
      end
    end
  endtask

  // Phases that saw a rising edge over a 64-cycle window
  task pulses(output [3:0] seen);
    reg [3:0] last;
    begin
      seen = 4'h0;
      last = phase_drive;
      repeat (64)
      begin
        @(negedge clock);
        seen = seen | (phase_drive & ~last);
        last = phase_drive;
      end
    end
  endtask

  task do_reset(input s2, input s4);
    begin
      cyc(1);
      rst <= 1'b1;
      enable_pin <= 1'b0;
      strap_second <= s2;
      strap_fourth <= s4;
      cyc(10);
      rst <= 1'b0;
      cyc(8);
    end
  endtask

  task t_ref;
    begin
      do_reset(1'b0, 1'b0);
      enable_pin <= 1'b1;
      cyc(40);
      chk(soft_start_active, 8'h0, "refbelow");
      cyc(1);
      ref_above_set <= 1'b1;
      cyc(10);
      chk(soft_start_active, 8'h1, "reference_valid");
      cyc(1);
      ref_above_set <= 1'b0;
      cyc(20);
      chk(soft_start_active, 8'h1, "refhyst");
      cyc(1);
      ref_above_clear <= 1'b0;
      cyc(10);
      chk(soft_start_active, 8'h0, "reflow");
      cyc(1);
      ref_above_set <= 1'b1;
      ref_above_clear <= 1'b1;
    end
  endtask

  task t_straps;
    integer k;
    begin
      for (k = 0; k < 3; k = k + 1)
      begin
        cyc(1);
        current_limit_set_pin <= (k != 1);
        do_reset(k == 0, k < 2);
        chk({5'h0, phase_count}, k[7:0] + 8'h2, "count");
        cyc(1);
        enable_pin <= 1'b1;
        cyc(20);
        chk(power_good_oe, 8'h1, "pgsoft");
        chk(current_limit_set_pin_threshold_mv, k == 1 ? 8'h14 : 8'ha, "fold");
        pulses(p);
        chk(p, k == 0 ? 8'h5 : (k == 1 ? 8'h7 : 8'hf), "phases");
      end
    end
  endtask

  task t_run;
    begin
      wait_dac(8'h41, 40000);
      chk(n > 31000, 8'h1, "ssrate");
      cyc(20);
      chk(power_good_oe, 8'h0, "pgrun");
      chk(pg_pin, 8'h0, "pgpin");
      chk(current_limit_set_pin_threshold_mv, 8'h14, "limit");
    end
  endtask

  task t_code;
    begin
      cyc(1);
      voltage_id_code <= 6'h37;
      cyc(50);
      voltage_id_code <= 6'h3f;
      cyc(700);
      chk(dac_level, 8'h41, "skew");
      cyc(1);
      voltage_id_code <= 6'h33;
      cyc(90);
      chk(dac_level, 8'h41, "filter");
      wait_dac(8'h4d, 8000);
      chk(n > 5400, 8'h1, "slew");
      cyc(1);
      voltage_id_code <= 6'h14;
      cyc(1500);
      chk(dac_level, 8'h4d, "window");
    end
  endtask

  task t_limit;
    begin
      cyc(1);
      force_over <= 4'h1;
      cyc(4);
      pulses(p);
      chk(p, 8'he, "skip");
      cyc(1);
      force_over <= 4'h0;
      out_below_pg_lo <= 1'b1;
      cyc(6);
      chk(current_limit_set_pin_threshold_mv, 8'ha, "foldlow");
      chk(power_good_oe, 8'h1, "pglow");
      cyc(1);
      out_below_pg_lo <= 1'b0;
      out_above_pg_hi <= 1'b1;
      cyc(6);
      chk(current_limit_set_pin_threshold_mv, 8'h14, "recover");
      chk(power_good_oe, 8'h1, "pghigh");
      cyc(1);
      out_above_pg_hi <= 1'b0;
      pulses(p);
      chk(p, 8'hf, "resume");
      cyc(1);
      master_mode <= 1'b0;
      pulses(p);
      chk(p, 8'hf, "slave");
      cyc(1);
      master_mode <= 1'b1;
    end
  endtask

  task t_faults;
    begin
      cyc(1);
      temp_over_trip <= 1'b1;
      cyc(6);
      chk(thermal_shutdown, 8'h1, "hot");
      chk(phase_drive, 8'h0, "hotoff");
      cyc(1);
      temp_over_trip <= 1'b0;
      cyc(10);
      chk(thermal_shutdown, 8'h1, "hyst");
      cyc(1);
      temp_cooled <= 1'b1;
      cyc(10);
      chk(soft_start_active, 8'h1, "cooled");
      cyc(1);
      temp_cooled <= 1'b0;
      supply_ok <= 1'b0;
      cyc(6);
      chk(phase_drive, 8'h0, "lockout");
      chk(soft_start_active, 8'h0, "lockss");
      cyc(1);
      supply_ok <= 1'b1;
      cyc(10);
      chk(soft_start_active, 8'h1, "restart");
    end
  endtask

  task t_overv;
    begin
      cyc(1);
      out_over_ovp <= 1'b1;
      cyc(6);
      chk(overvoltage_trip, 8'h1, "trip");
      chk(phase_drive, 8'h0, "tripoff");
      cyc(1);
      out_over_ovp <= 1'b0;
      enable_pin <= 1'b0;
      cyc(10);
      enable_pin <= 1'b1;
      cyc(20);
      chk(overvoltage_trip, 8'h1, "latched");
      chk(soft_start_active, 8'h0, "nostart");
      do_reset(1'b0, 1'b0);
      chk(overvoltage_trip, 8'h0, "cleared");
    end
  endtask

  initial
  begin
    t_ref;
    t_straps;
    t_run;
    t_code;
    t_limit;
    t_faults;
    t_overv;
    final_report;
  end
endmodule // mpfs_sequencer_tb_top
